// ===== rtl/ccd_board_ctrl.v
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
`include "ccd_seq_regs.vh"
// Behaviour
// R1 - Enabled decoder forwards each later command to its addressed subsection.
// R2 - Disabled decoder drops all commands except enable.
// R3 - Commander enables or disables listeners first, then sends commands.
// R4 - Program store holds two-16-bit-word entries executed in series.
// R5 - Header entry steers flow, repeating following entries a given count.
// R6 - Couplet carries pattern block index, repeat count and pixel code.
// R7 - Couplet runs its pattern block the given number of times.
// R8 - Pattern store is blocks of 64 sixteen-bit words.
// R9 - Each pattern bit drives one clock, video or preamp line.
// R10 - Each cycle the next pattern word is fetched and applied.
// R11 - Program store writable and readable by command.
// R12 - Pattern store writable and readable by command.
// R13 - Every converter level settable by command.
// R14 - Housekeeping select, digitise and return value by command.
// R15 - After reset decoder disabled, sequencer idle, outputs low.
module ccd_board_ctrl #(
	parameter PROG_AW = 8,
	parameter BLK_AW  = 4,
	parameter DAC_N   = 16
) (
	input  wire                 clock,
	input  wire                 rst_b,
	input  wire [7:0]           s_axi_awaddr,
	input  wire                 s_axi_awvalid,
	output wire                 s_axi_awready,
	input  wire [31:0]          s_axi_wdata,
	input  wire [3:0]           s_axi_wstrb,
	input  wire                 s_axi_wvalid,
	output wire                 s_axi_wready,
	output reg  [1:0]           s_axi_bresp,
	output reg                  s_axi_bvalid,
	input  wire                 s_axi_bready,
	input  wire [7:0]           s_axi_araddr,
	input  wire                 s_axi_arvalid,
	output wire                 s_axi_arready,
	output reg  [31:0]          s_axi_rdata,
	output reg  [1:0]           s_axi_rresp,
	output reg                  s_axi_rvalid,
	input  wire                 s_axi_rready,
	output wire [15:0]          ccdLines,
	output wire [3:0]           pixelCode,
	output reg  [4*DAC_N-1:0]   dacLevels,
	output reg  [3:0]           hkSelect,
	output reg                  hkConvert,
	input  wire [11:0]          hkSample
);
	////////////////////////////////////////////////////////////////
	// Storage
	reg [31:0]        progMem [0:(1<<PROG_AW)-1]; // [R4]
	reg [15:0]        patMem  [0:(1<<(BLK_AW+6))-1]; // [R8]
	reg [7:0]         rdAddr_reg;
	reg [11:0]        hkMeta_reg;
	reg [11:0]        hkSync_reg;
	reg               decEn_reg;
	reg               run_reg;
	reg [31:0]        cmdData_reg;
	reg [31:0]        resp_reg;
	reg               respValid_reg;
	reg               hkBusy_reg;
	reg [7:0]         hkCnt_reg;
	reg               awHeld_reg;
	reg               wHeld_reg;
	reg [7:0]         awAddr_reg;
	reg [31:0]        wData_reg;
	reg [3:0]         wStrb_reg;
	wire [PROG_AW-1:0]    progAddr;
	wire [BLK_AW+5:0]     patAddr;
	wire                  seqBusy;
	////////////////////////////////////////////////////////////////
	// Sequencer
	seq_engine #(
		.PROG_AW (PROG_AW),
		.BLK_AW  (BLK_AW)
	) engine (
		.clock     (clock),
		.rst_b     (rst_b),
		.run       (run_reg),
		.progEntry (progMem[progAddr]),
		.progAddr  (progAddr),
		.patWord   (patMem[patAddr]),
		.patAddr   (patAddr),
		.ccdLines  (ccdLines),
		.pixelCode (pixelCode),
		.busy      (seqBusy)
	);
	////////////////////////////////////////////////////////////////
	// AXI write channels
	assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_reg && !s_axi_bvalid;
	wire       awFire  = s_axi_awvalid && s_axi_awready;
	wire       wFire   = s_axi_wvalid && s_axi_wready;
	wire       haveAw  = awHeld_reg || awFire;
	wire       haveW   = wHeld_reg || wFire;
	wire       doWrite = haveAw && haveW;
	wire [7:0]  wAddr  = awHeld_reg ? awAddr_reg : s_axi_awaddr;
	wire [31:0] wData  = wHeld_reg ? wData_reg : s_axi_wdata;
	wire [3:0]  wStrb  = wHeld_reg ? wStrb_reg : s_axi_wstrb;
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  be;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1)
				merge[8*k +: 8] = be[k] ? nw[8*k +: 8] : old[8*k +: 8];
		end
	endfunction
	function mapped;
		input [7:0] a;
		begin
			mapped = (a == `OFS_CMD) || (a == `OFS_CMDDATA) || (a == `OFS_STATUS) ||
				(a == `OFS_RESP) || (a == `OFS_DECEN);
		end
	endfunction
	wire        cmdStrobe = doWrite && wAddr == `OFS_CMD && wStrb == 4'hF;
	wire [3:0]  op        = wData[31:28];
	wire [15:0] arg       = wData[15:0];
	// Disabled decoder drops everything but the enable opcode
	wire        cmdPass   = cmdStrobe && (decEn_reg || op == `OP_ENABLE); // [R1] [R2]
	always @(posedge clock) begin
		if (!rst_b) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wData_reg <= 32'h00000000;
			wStrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			cmdData_reg <= 32'h00000000;
			decEn_reg <= 1'b0; // [R15]
			run_reg <= 1'b0; // [R15]
			dacLevels <= {4*DAC_N{1'b0}};
			hkSelect <= 4'h0;
		end else begin
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(wAddr) ? 2'h0 : 2'h2;
			end else begin
				if (awFire) begin
					awHeld_reg <= 1'b1;
					awAddr_reg <= s_axi_awaddr;
				end
				if (wFire) begin
					wHeld_reg <= 1'b1;
					wData_reg <= s_axi_wdata;
					wStrb_reg <= s_axi_wstrb;
				end
			end
			if (doWrite && wAddr == `OFS_CMDDATA)
				cmdData_reg <= merge(cmdData_reg, wData, wStrb);
			if (cmdPass) begin
				case (op)
				`OP_ENABLE:  decEn_reg <= 1'b1;
				`OP_DISABLE: decEn_reg <= 1'b0;
				`OP_RUN:     run_reg <= 1'b1;
				`OP_STOP:    run_reg <= 1'b0;
				`OP_DAC_WR:  dacLevels[4*arg[3:0] +: 4] <= cmdData_reg[3:0]; // [R13]
				`OP_HK_RD:   hkSelect <= arg[3:0]; // [R14]
				default: ;
				endcase
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// Stores; no interlock, so a write while running lands on the next fetch
	always @(posedge clock) begin
		if (cmdPass && op == `OP_PROG_WR)
			progMem[arg[PROG_AW-1:0]] <= cmdData_reg; // [R11]
		if (cmdPass && op == `OP_PAT_WR)
			patMem[arg[BLK_AW+5:0]] <= cmdData_reg[15:0]; // [R12]
	end
	////////////////////////////////////////////////////////////////
	// Converter result comes in from the pins; it is stable long
	// before capture, so per-bit skew through the two flops is harmless
	always @(posedge clock) begin
		if (!rst_b) begin
			hkMeta_reg <= 12'h000;
			hkSync_reg <= 12'h000;
		end else begin
			hkMeta_reg <= hkSample;
			hkSync_reg <= hkMeta_reg;
		end
	end
	////////////////////////////////////////////////////////////////
	// Status responses
	always @(posedge clock) begin
		if (!rst_b) begin
			resp_reg <= 32'h00000000;
			respValid_reg <= 1'b0;
			hkBusy_reg <= 1'b0;
			hkCnt_reg <= 8'h00;
			hkConvert <= 1'b0;
		end else begin
			hkConvert <= 1'b0;
			// Reading the response clears its flag; a new event below wins
			if (s_axi_rvalid && s_axi_rready && rdAddr_reg == `OFS_RESP)
				respValid_reg <= 1'b0;
			if (cmdPass && op == `OP_HK_RD) begin
				hkBusy_reg <= 1'b1; // [R14]
				hkConvert <= 1'b1;
				hkCnt_reg <= `HK_CONV_CYCLES;
				respValid_reg <= 1'b0;
			end else if (hkBusy_reg) begin
				// Fixed wait covers converter settling; no done pin exists
				hkCnt_reg <= hkCnt_reg - 8'h01;
				if (hkCnt_reg == 8'h01) begin
					hkBusy_reg <= 1'b0;
					resp_reg <= {20'h00000, hkSync_reg}; // [R14]
					respValid_reg <= 1'b1;
				end
			end
			if (cmdPass && op == `OP_PROG_RD) begin
				resp_reg <= progMem[arg[PROG_AW-1:0]]; // [R11]
				respValid_reg <= 1'b1;
			end
			if (cmdPass && op == `OP_PAT_RD) begin
				resp_reg <= {16'h0000, patMem[arg[BLK_AW+5:0]]}; // [R12]
				respValid_reg <= 1'b1;
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// AXI read channel
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge clock) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
			rdAddr_reg <= 8'h00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			rdAddr_reg <= s_axi_araddr;
			s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
			case (s_axi_araddr)
			`OFS_CMDDATA: s_axi_rdata <= cmdData_reg;
			`OFS_STATUS:  s_axi_rdata <= {28'h0000000, hkBusy_reg, respValid_reg, seqBusy, run_reg};
			`OFS_RESP:    s_axi_rdata <= resp_reg;
			`OFS_DECEN:   s_axi_rdata <= {31'h00000000, decEn_reg};
			default:      s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// ===== rtl/ccd_seq_regs.vh
`ifndef CCD_SEQ_REGS_VH
`define CCD_SEQ_REGS_VH
// Register byte offsets
`define OFS_CMD        8'h00
`define OFS_CMDDATA    8'h04
`define OFS_STATUS     8'h08
`define OFS_RESP       8'h0C
`define OFS_DECEN      8'h10
// Command opcodes (bits 31:28 of command word)
`define OP_ENABLE      4'h1
`define OP_DISABLE     4'h2
`define OP_PROG_WR     4'h3
`define OP_PROG_RD     4'h4
`define OP_PAT_WR      4'h5
`define OP_PAT_RD      4'h6
`define OP_DAC_WR      4'h7
`define OP_HK_RD       4'h8
`define OP_RUN         4'h9
`define OP_STOP        4'hA
// Program entry fields (word0 = type/flow, word1 = data)
`define ENT_TYPE_BIT   15
`define ENT_END_BIT    14
`define HDR_COUNT_MSB  7
`define CPL_BLOCK_MSB  13
`define CPL_BLOCK_LSB  8
`define CPL_CODE_MSB   3
`define CPL_REP_MSB    15
// Misc
`define PAT_BLOCK_WORDS 64
`define HK_CONV_CYCLES  8'h20
`endif

// ===== rtl/seq_engine.v
`timescale 1ns/1ns
// Two-level sequencer: program entries invoke 64-word pattern blocks
module seq_engine #(
	parameter PROG_AW = 8,
	parameter BLK_AW  = 4
) (
	input  wire                    clock,
	input  wire                    rst_b,
	input  wire                    run,
	input  wire [31:0]             progEntry,
	output reg  [PROG_AW-1:0]      progAddr,
	input  wire [15:0]             patWord,
	output wire [BLK_AW+5:0]       patAddr,
	output reg  [15:0]             ccdLines,
	output reg  [3:0]              pixelCode,
	output reg                     busy
);
	localparam S_IDLE = 3'b001;
	localparam S_ENT  = 3'b010;
	localparam S_PAT  = 3'b100;
	reg [2:0]         state_reg;
	reg [BLK_AW-1:0]  blk_reg;
	reg [5:0]         word_reg;
	reg [15:0]        rep_reg;
	reg [PROG_AW-1:0] loopStart_reg;
	reg [7:0]         loopCnt_reg;
	reg               inLoop_reg;
	wire [15:0] w0 = progEntry[31:16];
	wire [15:0] w1 = progEntry[15:0];
	assign patAddr = {blk_reg, word_reg};
	always @(posedge clock) begin
		if (!rst_b) begin
			state_reg <= S_IDLE;
			progAddr <= {PROG_AW{1'b0}};
			blk_reg <= {BLK_AW{1'b0}};
			word_reg <= 6'h00;
			rep_reg <= 16'h0000;
			loopStart_reg <= {PROG_AW{1'b0}};
			loopCnt_reg <= 8'h00;
			inLoop_reg <= 1'b0;
			ccdLines <= 16'h0000; // [R15]
			pixelCode <= 4'h0;
			busy <= 1'b0;
		end else begin
			case (state_reg)
			S_IDLE: begin
				ccdLines <= 16'h0000; // [R15]
				progAddr <= {PROG_AW{1'b0}};
				inLoop_reg <= 1'b0;
				busy <= 1'b0;
				if (run) begin
					busy <= 1'b1;
					state_reg <= S_ENT;
				end
			end
			S_ENT: begin
				if (!run || w0[`ENT_END_BIT]) begin
					state_reg <= S_IDLE;
				end else if (!w0[`ENT_TYPE_BIT]) begin
					// Header: repeat following entries up to next header-end marker [R5]
					if (w0[`HDR_COUNT_MSB:0] == 8'h00) begin
						if (inLoop_reg && loopCnt_reg > 8'h01) begin
							loopCnt_reg <= loopCnt_reg - 8'h01;
							progAddr <= loopStart_reg;
						end else begin
							inLoop_reg <= 1'b0;
							progAddr <= progAddr + 1'b1; // [R4]
						end
					end else begin
						inLoop_reg <= 1'b1;
						loopCnt_reg <= w0[`HDR_COUNT_MSB:0];
						loopStart_reg <= progAddr + 1'b1;
						progAddr <= progAddr + 1'b1;
					end
				end else begin
					// Couplet fields [R6]
					blk_reg <= w0[`CPL_BLOCK_LSB+BLK_AW-1:`CPL_BLOCK_LSB];
					pixelCode <= w0[`CPL_CODE_MSB:0];
					rep_reg <= w1[`CPL_REP_MSB:0];
					word_reg <= 6'h00;
					progAddr <= progAddr + 1'b1;
					if (w1 != 16'h0000)
						state_reg <= S_PAT;
				end
			end
			S_PAT: begin
				ccdLines <= patWord; // [R9] [R10]
				word_reg <= word_reg + 6'h01; // [R10]
				if (!run) begin
					state_reg <= S_IDLE;
				end else if (word_reg == 6'h3F) begin
					rep_reg <= rep_reg - 16'h0001; // [R7]
					if (rep_reg == 16'h0001)
						state_reg <= S_ENT;
				end
			end
			default: state_reg <= S_IDLE;
			endcase
		end
	end
endmodule

// ===== sim/board_ctrl_properties.sv
`timescale 1ns/1ns
module board_ctrl_properties (
	input wire        clock,
	input wire        rst_b,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire [15:0] ccdLines,
	input wire        hkConvert
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	//////////////////////////////////////////
	// Checked through reset itself, so no disable here
	a_reset_clears: assert property (disable iff (1'b0) !rst_b |=> ccdLines == 16'h0000)
		else $error("lines not cleared by reset");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
		else $error("write answer missing");
	a_write_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer held too long");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken during answer");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_read_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer held too long");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken during answer");
	a_convert_pulse: assert property (hkConvert |=> !hkConvert)
		else $error("convert pulse too long");
endmodule

// ===== sim/proc_master.sv
`timescale 1ns/1ns
module proc_master (
	input  wire        clock,
	output reg  [7:0]  s_axi_awaddr,
	output reg         s_axi_awvalid,
	input  wire        s_axi_awready,
	output reg  [31:0] s_axi_wdata,
	output reg  [3:0]  s_axi_wstrb,
	output reg         s_axi_wvalid,
	input  wire        s_axi_wready,
	input  wire [1:0]  s_axi_bresp,
	input  wire        s_axi_bvalid,
	output reg         s_axi_bready,
	output reg  [7:0]  s_axi_araddr,
	output reg         s_axi_arvalid,
	input  wire        s_axi_arready,
	input  wire [31:0] s_axi_rdata,
	input  wire [1:0]  s_axi_rresp,
	input  wire        s_axi_rvalid,
	output reg         s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	//////////////////////////////////////////
	// Full word strobes, command writes refuse partial ones
	task wr(input [7:0] a, input [31:0] d, output [1:0] r);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		while (!s_axi_bvalid) @(posedge clock);
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask
	task rd(input [7:0] a, output [31:0] d, output [1:0] r);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge clock); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
endmodule

// ===== sim/tb_top.sv
`timescale 1ns/1ns
`include "ccd_seq_regs.vh"
module tb_top;
	reg         clock = 1'b0;
	reg         rst_b = 1'b0;
	reg  [11:0] hkSample = 12'h000;
	wire [7:0]  s_axi_awaddr, s_axi_araddr;
	wire [31:0] s_axi_wdata, s_axi_rdata;
	wire [3:0]  s_axi_wstrb, hkSelect, pixelCode;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [15:0] ccdLines;
	wire [63:0] dacLevels;
	wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	wire        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, hkConvert;
	int         mismatches = 0;
	int         comparisons = 0;
	int         n;
	int         p;
	reg  [31:0] rv;
	reg  [1:0]  rr;
	reg  [31:0] prog [0:3];
	ccd_board_ctrl ccd_board_ctrl_i (.*);
	proc_master proc_master_i (.*);
	always #4 clock = ~clock;
	// Converter result held until the next conversion
	always @(posedge clock) if (hkConvert) hkSample <= {8'hA5, hkSelect};
	//////////////////////////////////////////
	task chk(input [31:0] got, input [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cmd(input [3:0] op, input [15:0] arg, input [31:0] d);
		proc_master_i.wr(`OFS_CMDDATA, d, rr);
		proc_master_i.wr(`OFS_CMD, {op, 12'h000, arg}, rr);
		@(posedge clock);
	endtask
	task rdc(input [7:0] a, input [31:0] exp);
		proc_master_i.rd(a, rv, rr);
		chk(rv, exp);
	endtask
	task print_verdict;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	//////////////////////////////////////////
	// Whole run needs about a thousand cycles
	initial begin
		repeat (30000) @(posedge clock);
		mismatches++;
		print_verdict;
	end
	initial begin
		prog[0] = 32'h0002_0000;
		prog[1] = 32'h8103_0002;
		prog[2] = 32'h0000_0000;
		prog[3] = 32'h4000_0000;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		chk({16'h0000, ccdLines}, 32'h0);
		rdc(`OFS_DECEN, 32'h0);
		cmd(`OP_DAC_WR, 16'h0002, 32'h5);
		chk(dacLevels[31:0], 32'h0);
		cmd(`OP_ENABLE, 16'h0000, 32'h0);
		rdc(`OFS_DECEN, 32'h1);
		cmd(`OP_DAC_WR, 16'h0002, 32'h5);
		chk(dacLevels[31:0], 32'h0000_0500);
		for (n = 0; n < 64; n++) cmd(`OP_PAT_WR, 16'h0040 + n, 32'h0100 + n);
		cmd(`OP_PAT_RD, 16'h0045, 32'h0);
		rdc(`OFS_RESP, 32'h0000_0105);
		for (n = 0; n < 4; n++) cmd(`OP_PROG_WR, n, prog[n]);
		cmd(`OP_PROG_RD, 16'h0001, 32'h0);
		rdc(`OFS_RESP, 32'h8103_0002);
		proc_master_i.rd(8'h14, rv, rr);
		chk({30'h0, rr}, 32'h2);
		chk(rv, 32'h0);
		proc_master_i.wr(8'h14, 32'h1, rr);
		chk({30'h0, rr}, 32'h2);
		cmd(`OP_HK_RD, 16'h0005, 32'h0);
		chk({28'h0, hkSelect}, 32'h5);
		rv = 32'h0;
		for (n = 0; n < 30 && rv[2] !== 1'b1; n++) proc_master_i.rd(`OFS_STATUS, rv, rr);
		rdc(`OFS_RESP, 32'h0000_0A55);
		proc_master_i.wr(`OFS_CMD, {`OP_RUN, 28'h0}, rr);
		chk({30'h0, rr}, 32'h0);
		// Loop of two around a couplet of two: four passes
		for (p = 0; p < 4; p++) begin
			for (n = 0; n < 64; n++) begin
				if (n == 0) begin
					for (int w = 0; w < 16 && ccdLines !== 16'h0100; w++) @(posedge clock);
				end else begin
					@(posedge clock);
				end
				chk({16'h0, ccdLines}, 32'h0100 + n);
				if (n == 5) chk({28'h0, pixelCode}, 32'h3);
			end
		end
		for (n = 0; n < 16 && ccdLines !== 16'h0; n++) @(posedge clock);
		chk({16'h0, ccdLines}, 32'h0);
		rdc(`OFS_STATUS, 32'h3);
		cmd(`OP_DISABLE, 16'h0000, 32'h0);
		cmd(`OP_DAC_WR, 16'h0003, 32'h9);
		chk(dacLevels[31:0], 32'h0000_0500);
		cmd(`OP_STOP, 16'h0000, 32'h0);
		rdc(`OFS_STATUS, 32'h3);
		cmd(`OP_ENABLE, 16'h0000, 32'h0);
		cmd(`OP_STOP, 16'h0000, 32'h0);
		rdc(`OFS_STATUS, 32'h0);
		chk({16'h0, ccdLines}, 32'h0);
		// Second reset while running: all must come back quiet
		cmd(`OP_RUN, 16'h0000, 32'h0);
		rst_b <= 1'b0;
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		chk({12'h0, pixelCode, ccdLines}, 32'h0);
		chk(dacLevels[31:0], 32'h0);
		rdc(`OFS_DECEN, 32'h0);
		rdc(`OFS_STATUS, 32'h0);
		print_verdict;
	end
endmodule
bind ccd_board_ctrl board_ctrl_properties board_ctrl_properties_i (.*);
